// ==== hw/dcpwm_pkg.sv ====
// package: register map, field positions, reset values and counts for the dual-channel modulator
package dcpwm_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] DCPWM_OFF_ENPS  = 8'h00;   // pwm_enable_and_prescale
   localparam logic [7:0] DCPWM_OFF_RES   = 8'h04;   // pwm_resolution_select
   localparam logic [7:0] DCPWM_OFF_DUTY1 = 8'h08;   // channel_one_duty
   localparam logic [7:0] DCPWM_OFF_DUTY2 = 8'h0C;   // channel_two_duty
   localparam logic [7:0] DCPWM_OFF_STAT  = 8'h10;   // live counter and pin state
   // field positions in pwm_enable_and_prescale
   localparam int DCPWM_CH2_EN_BIT = 7;
   localparam int DCPWM_CH2_PS_LSB = 4;
   localparam int DCPWM_CH1_EN_BIT = 3;
   localparam int DCPWM_CH1_PS_LSB = 0;
   // field positions in pwm_resolution_select
   localparam int DCPWM_MODE_BIT   = 0;
   localparam int DCPWM_VRST_LSB   = 6;
   // reset values
   localparam logic [7:0] DCPWM_RST_ENPS = 8'h00;
   localparam logic [7:0] DCPWM_RST_RES  = 8'h00;
   localparam logic [7:0] DCPWM_RST_DUTY = 8'h00;
   // prescaler counter width: largest ratio is 256 clocks
   localparam int DCPWM_PS_W = 8;
   // axi responses
   localparam logic [1:0] DCPWM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] DCPWM_RESP_SLVERR = 2'h2;
   // bus slave states
   typedef enum logic [1:0] {DCPWM_W_IDLE, DCPWM_W_RESP} dcpwm_wst_t;
endpackage

// ==== hw/dcpwm_prescaler.sv ====
// module: per-channel oscillator divider giving a one-cycle tick at fosc/2^(code+1)
`timescale 1ns/1ps
module dcpwm_prescaler
   import dcpwm_pkg::*;
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // control
   input  wire logic [2:0] prescale_select,
   // tick out
   output logic            tick
);
   logic [DCPWM_PS_W-1:0] div_count;   // free-running divider

   // divider counts oscillator clocks only, no other source [RULE2]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   // tick when the low code+1 bits are all ones: ratio 2..256 [RULE5]
   always_comb begin
      logic [DCPWM_PS_W-1:0] mask;
      mask = 8'hFF >> (3'h7 - prescale_select);
      tick = ((div_count & mask) == mask);
   end

   // a tick is never two cycles in a row since the ratio is at least 2
   tick_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
      tick |=> !tick) else $error("prescaler tick repeated");
endmodule

// ==== hw/dcpwm_channel.sv ====
// module: one modulator output compare with period-start duty latch and enable gating
`timescale 1ns/1ps
module dcpwm_channel
   import dcpwm_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // timing
   input  wire logic        tick,
   input  wire logic        period_start,
   input  wire logic [15:0] count,
   // control
   input  wire logic [15:0] duty,
   input  wire logic        enable,
   // pin
   output logic             pin_o,
   output logic             pin_oe_n
);
   logic [15:0] duty_live;   // duty in force for the current period

   // duty reloads at period start or while disabled, so a mid-period write waits [RULE17]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_live <= '0;
      end else if (period_start || !enable) begin
         duty_live <= duty;
      end
   end

   // high while counter below duty; zero duty stays low [RULE16]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_o <= 1'b0;
      end else if (tick || !enable) begin
         pin_o <= enable && (count < (period_start ? duty : duty_live));
      end
   end

   // enable low floats the pin (active-low enable high) [RULE4]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_oe_n <= 1'b1;
      end else begin
         pin_oe_n <= !enable;
      end
   end
endmodule

// ==== hw/dcpwm_top.sv ====
// module: dual-channel pulse width modulator with axi4-lite register slave
//
// Behaviour
// RULE1: two independent channels, 8-bit duty default
// RULE2: counter clocked from oscillator via prescaler only
// RULE3: enable bits: bit7 channel two, bit3 one
// RULE4: disabled channel pin is high impedance
// RULE5: 3-bit prescale codes divide by 2..256
// RULE6: 8-bit period is prescale times 256
// RULE7: 16-bit period is prescale times 65536
// RULE8: mode bit 0 selects 16-bit, resets 0
// RULE9: 16-bit mode drives only channel one; channel two still runs its 8-bit waveform when enabled
// RULE10: 16-bit duty is duty2 high, duty1 low
// RULE11: channel one duty is duty1 over 256
// RULE12: channel two duty is duty2 over 256
// RULE13: channel two drives port 2 bit 0
// RULE14: channel one drives port 3 bit 6
// RULE15: resolution bits 7:6 are voltage-reset control
// RULE16: high while counter below duty, zero low
// RULE17: counter wraps; duty updates at period start
`timescale 1ns/1ps
module dcpwm_top
   import dcpwm_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // port 3 bit 6 pin: channel one
   output logic             p3_6_o,
   output logic             p3_6_oe_n,
   // port 2 bit 0 pin: channel two
   output logic             p2_0_o,
   output logic             p2_0_oe_n,
   // voltage-reset control bits held for the supply monitor
   output logic [1:0]       low_voltage_reset_ctrl
);
   // registers
   logic [7:0]  pwm_enable_and_prescale;   // enables and prescale codes
   logic        mode_16;                   // resolution select bit
   logic [7:0]  channel_one_duty;          // duty 1 or low byte
   logic [7:0]  channel_two_duty;          // duty 2 or high byte
   // bus state
   logic        aw_held;                   // write address taken
   logic        w_held;                    // write data taken
   logic [7:0]  aw_addr;                   // taken write address
   logic [31:0] w_data;                    // taken write data
   logic [3:0]  w_strb;                    // taken strobes
   logic        w_fire;                    // both halves present
   logic        w_hit;                     // address decodes
   // fields
   logic        channel_one_enable;
   logic        channel_two_enable;
   logic [2:0]  channel_one_prescale;
   logic [2:0]  channel_two_prescale;
   // timing
   logic        tick1, tick2;              // per-channel count enables
   logic [15:0] count1;                    // channel one counter
   logic [7:0]  count2;                    // channel two counter
   logic        start1, start2;            // counter at zero on a tick
   logic [15:0] duty1_sel;                 // channel one duty by mode
   logic        pin1_o, pin1_oe_n, pin2_o, pin2_oe_n;

   // field split [RULE3] [RULE5]
   assign channel_two_enable   = pwm_enable_and_prescale[DCPWM_CH2_EN_BIT];
   assign channel_one_enable   = pwm_enable_and_prescale[DCPWM_CH1_EN_BIT];
   assign channel_two_prescale = pwm_enable_and_prescale[DCPWM_CH2_PS_LSB +: 3];
   assign channel_one_prescale = pwm_enable_and_prescale[DCPWM_CH1_PS_LSB +: 3];

   // ---------------- write channel ----------------
   assign w_fire = aw_held && w_held && !s_axi_bvalid;
   assign w_hit  = (aw_addr == DCPWM_OFF_ENPS) || (aw_addr == DCPWM_OFF_RES)
                || (aw_addr == DCPWM_OFF_DUTY1) || (aw_addr == DCPWM_OFF_DUTY2)
                || (aw_addr == DCPWM_OFF_STAT);

   // address and data are caught in either order, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (w_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (w_fire) begin
         w_held <= 1'b0;
      end
   end

   // ready registered: high only while that half is not yet held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // response one cycle after both halves meet
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= DCPWM_RESP_OKAY;
      end else if (w_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= w_hit ? DCPWM_RESP_OKAY : DCPWM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes, byte lane 0 only (8-bit registers)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_enable_and_prescale <= DCPWM_RST_ENPS;
         mode_16                 <= DCPWM_RST_RES[DCPWM_MODE_BIT];  // [RULE8]
         low_voltage_reset_ctrl  <= DCPWM_RST_RES[DCPWM_VRST_LSB +: 2];
         channel_one_duty        <= DCPWM_RST_DUTY;
         channel_two_duty        <= DCPWM_RST_DUTY;
      end else if (w_fire && w_strb[0]) begin
         if (aw_addr == DCPWM_OFF_ENPS) begin
            pwm_enable_and_prescale <= w_data[7:0];
         end else if (aw_addr == DCPWM_OFF_RES) begin
            // each field written from its own bits only [RULE15]
            mode_16                <= w_data[DCPWM_MODE_BIT];
            low_voltage_reset_ctrl <= w_data[DCPWM_VRST_LSB +: 2];
         end else if (aw_addr == DCPWM_OFF_DUTY1) begin
            channel_one_duty <= w_data[7:0];
         end else if (aw_addr == DCPWM_OFF_DUTY2) begin
            channel_two_duty <= w_data[7:0];
         end
      end
   end

   // ---------------- read channel ----------------
   // single-cycle answer; arready drops while rvalid stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= DCPWM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= DCPWM_RESP_OKAY;
         if (s_axi_araddr[7:2] == DCPWM_OFF_ENPS[7:2]) begin
            s_axi_rdata <= {24'h000000, pwm_enable_and_prescale};
         end else if (s_axi_araddr[7:2] == DCPWM_OFF_RES[7:2]) begin
            s_axi_rdata <= {24'h000000, low_voltage_reset_ctrl, 5'h00, mode_16};
         end else if (s_axi_araddr[7:2] == DCPWM_OFF_DUTY1[7:2]) begin
            s_axi_rdata <= {24'h000000, channel_one_duty};
         end else if (s_axi_araddr[7:2] == DCPWM_OFF_DUTY2[7:2]) begin
            s_axi_rdata <= {24'h000000, channel_two_duty};
         end else if (s_axi_araddr[7:2] == DCPWM_OFF_STAT[7:2]) begin
            // live state: pins, channel two and one counters
            s_axi_rdata <= {6'h00, p2_0_o, p3_6_o, count2, count1};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DCPWM_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- modulator ----------------
   // one prescaler per channel from the oscillator clock [RULE2]
   dcpwm_prescaler u_ps1 (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .prescale_select (channel_one_prescale),
      .tick            (tick1)
   );
   dcpwm_prescaler u_ps2 (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .prescale_select (channel_two_prescale),
      .tick            (tick2)
   );

   // channel one counter: wraps at 255 or 65535 by mode [RULE6] [RULE7] [RULE17]
   always_ff @(posedge aclk) begin
      if (!aresetn || !channel_one_enable) begin
         count1 <= 16'h0000;
      end else if (tick1) begin
         count1 <= mode_16 ? count1 + 16'h0001 : {8'h00, count1[7:0] + 8'h01};
      end
   end

   // channel two counter always 8 bits: no 16-bit waveform here [RULE9]
   always_ff @(posedge aclk) begin
      if (!aresetn || !channel_two_enable) begin
         count2 <= 8'h00;
      end else if (tick2) begin
         count2 <= count2 + 8'h01;
      end
   end

   assign start1 = tick1 && (count1 == 16'h0000);
   assign start2 = tick2 && (count2 == 8'h00);
   // mode picks concatenated or 8-bit duty [RULE10] [RULE11]
   assign duty1_sel = mode_16 ? {channel_two_duty, channel_one_duty} : {8'h00, channel_one_duty};

   // two independent channel compares [RULE1]
   dcpwm_channel u_ch1 (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .tick         (tick1),
      .period_start (start1),
      .count        (count1),
      .duty         (duty1_sel),
      .enable       (channel_one_enable),
      .pin_o        (pin1_o),
      .pin_oe_n     (pin1_oe_n)
   );
   dcpwm_channel u_ch2 (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .tick         (tick2),
      .period_start (start2),
      .count        ({8'h00, count2}),
      .duty         ({8'h00, channel_two_duty}),  // [RULE12]
      .enable       (channel_two_enable),
      .pin_o        (pin2_o),
      .pin_oe_n     (pin2_oe_n)
   );

   // pin mapping: channel one to port 3 bit 6, two to port 2 bit 0 [RULE14] [RULE13]
   assign p3_6_o    = pin1_o;
   assign p3_6_oe_n = pin1_oe_n;
   assign p2_0_o    = pin2_o;
   assign p2_0_oe_n = pin2_oe_n;

   // ---------------- checks ----------------
   float_when_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
      !channel_one_enable |=> p3_6_oe_n) else $error("channel one driven while disabled");
   ch2_float_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
      !channel_two_enable |=> p2_0_oe_n) else $error("channel two driven while disabled");
   zero_duty_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE16]
      (channel_two_enable && start2 && channel_two_duty == 8'h00)
      |=> !p2_0_o) else $error("zero duty gave high output");
   wrap_8bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
      (!mode_16 && tick1) |=> count1[15:8] == 8'h00)
      else $error("8-bit counter exceeded 255");
   ch2_8bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
      (channel_two_enable && tick2 && count2 == 8'hFF) |=> count2 == 8'h00)
      else $error("channel two counter did not wrap");
   wrap_16bit_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
      (mode_16 && channel_one_enable && tick1 && count1 == 16'hFFFF) |=> count1 == 16'h0000)
      else $error("16-bit counter did not wrap");
   mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
      (w_fire && w_strb[0] && aw_addr == DCPWM_OFF_RES) |=> mode_16 == $past(w_data[0]))
      else $error("mode bit not written");
   vrst_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
      (w_fire && aw_addr != DCPWM_OFF_RES) |=> $stable(low_voltage_reset_ctrl))
      else $error("voltage-reset bits disturbed");
   bus_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      w_fire |=> s_axi_bvalid) else $error("write response missing");

   ch1_period_c: cover property (@(posedge aclk) disable iff (!aresetn)
      channel_one_enable && start1 && p3_6_o);
   mode16_c: cover property (@(posedge aclk) disable iff (!aresetn)
      mode_16 && channel_one_enable && count1[15:8] != 8'h00);
   ch2_high_c: cover property (@(posedge aclk) disable iff (!aresetn)
      channel_two_enable && $rose(p2_0_o));
endmodule

// ==== verification/dcpwm_load.sv ====
// file: external load on the two modulator pins, with a resistive pull-down
`timescale 1ns/1ps
module dcpwm_load (
   // pin drives from the modulator
   input  wire logic ch1_o,
   input  wire logic ch1_oe_n,
   input  wire logic ch2_o,
   input  wire logic ch2_oe_n,
   // levels seen across the load
   output logic      ch1_lvl,
   output logic      ch2_lvl
);
   // a released pin sinks to the pull-down, so a stale drive value never shows
   assign ch1_lvl = ch1_oe_n ? 1'b0 : ch1_o;
   assign ch2_lvl = ch2_oe_n ? 1'b0 : ch2_o;
endmodule

// ==== verification/dcpwm_tb_top.sv ====
// file: self-checking bench for the dual-channel modulator
`timescale 1ns/1ps
module dcpwm_tb_top
   import dcpwm_pkg::*;
;
   // clock, reset and bus signals driven by the bench
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   // design outputs
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, vrst_bits;
   logic [31:0] rdata;
   logic        p1_o, p1_oe_n, p2_o, p2_oe_n, lvl1, lvl2;
   // score keeping
   int          mismatches, checks_done;

   dcpwm_top dcpwm_top_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .p3_6_o(p1_o), .p3_6_oe_n(p1_oe_n), .p2_0_o(p2_o), .p2_0_oe_n(p2_oe_n),
      .low_voltage_reset_ctrl(vrst_bits));

   dcpwm_load dcpwm_load_i (.ch1_o(p1_o), .ch1_oe_n(p1_oe_n), .ch2_o(p2_o), .ch2_oe_n(p2_oe_n),
      .ch1_lvl(lvl1), .ch2_lvl(lvl2));

   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // exact comparison
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one write: address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      int n;
      r = 2'h3;
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= {24'h000000, d}; wstrb <= s; wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // one read; a hung slave leaves the unused response code behind
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      r = 2'h3;
      d = 32'hFFFFFFFF;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // plain write expected to be accepted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_write(a, d, 4'hF, r);
      check({30'h0, r}, {30'h0, DCPWM_RESP_OKAY});
   endtask

   // read expecting OKAY and a given value
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check({30'h0, r}, {30'h0, DCPWM_RESP_OKAY});
      check(d, exp);
   endtask

   // from a rising edge: high cycles, and cycles to the next rise when full is set
   task automatic measure(input bit ch2, input int lim, input bit full, output int hi, output int per);
      int n;
      logic prv, cur;
      n = 0; hi = 0; per = 0; prv = 1'b1; cur = 1'b1;
      while (n < lim && !(!prv && cur)) begin
         @(posedge aclk);
         prv = cur; cur = ch2 ? lvl2 : lvl1; n++;
      end
      while (n < lim) begin
         if (cur === 1'b1) hi++;
         per++;
         @(posedge aclk);
         prv = cur; cur = ch2 ? lvl2 : lvl1; n++;
         if (!full && !cur) break;
         if (!prv && cur) break;
      end
   endtask

   // reset values, register access kinds, strobe and unmapped offset
   task automatic test_regs();
      logic [31:0] d;
      logic [1:0]  r;
      check({31'h0, p1_oe_n & p2_oe_n}, 32'h00000001);
      rd_chk(DCPWM_OFF_ENPS, 32'h00000000);
      rd_chk(DCPWM_OFF_RES, 32'h00000000);
      rd_chk(DCPWM_OFF_DUTY1, 32'h00000000);
      rd_chk(DCPWM_OFF_DUTY2, 32'h00000000);
      rd_chk(DCPWM_OFF_STAT, 32'h00000000);
      wr(DCPWM_OFF_STAT, 8'h55);
      rd_chk(DCPWM_OFF_STAT, 32'h00000000);
      wr(DCPWM_OFF_RES, 8'hFF);
      rd_chk(DCPWM_OFF_RES, 32'h000000C1);
      check({30'h0, vrst_bits}, 32'h00000003);
      wr(DCPWM_OFF_RES, 8'h00);
      check({30'h0, vrst_bits}, 32'h00000000);
      axi_write(DCPWM_OFF_DUTY1, 8'h5A, 4'h0, r);
      check({30'h0, r}, {30'h0, DCPWM_RESP_OKAY});
      rd_chk(DCPWM_OFF_DUTY1, 32'h00000000);
      axi_write(8'h20, 8'h11, 4'hF, r);
      check({30'h0, r}, {30'h0, DCPWM_RESP_SLVERR});
      axi_read(8'h20, d, r);
      check({30'h0, r}, {30'h0, DCPWM_RESP_SLVERR});
      check(d, 32'h00000000);
      $display("test regs done");
   endtask

   // channel one: enable bit, duty, period, mid-period update, zero duty, release
   task automatic test_ch1();
      int hi, per, n;
      wr(DCPWM_OFF_DUTY1, 8'h40);
      wr(DCPWM_OFF_ENPS, 8'h08);
      // pin enable flop follows the register one edge later
      repeat (2) @(posedge aclk);
      check({30'h0, p1_oe_n, p2_oe_n}, 32'h00000001);
      measure(1'b0, 1200, 1'b1, hi, per);
      check(per, 32'd512);
      check(hi, 32'd128);
      measure(1'b0, 1200, 1'b0, hi, per);
      repeat (100) @(posedge aclk);
      wr(DCPWM_OFF_DUTY1, 8'hC0);
      repeat (2) @(posedge aclk);
      check({31'h0, lvl1}, 32'h00000000);
      measure(1'b0, 1200, 1'b0, hi, per);
      check(hi, 32'd384);
      wr(DCPWM_OFF_DUTY1, 8'h00);
      repeat (600) @(posedge aclk);
      hi = 0;
      for (n = 0; n < 600; n++) begin
         @(posedge aclk);
         if (lvl1 !== 1'b0) hi++;
      end
      check(hi, 32'd0);
      wr(DCPWM_OFF_ENPS, 8'h00);
      repeat (2) @(posedge aclk);
      check({31'h0, p1_oe_n}, 32'h00000001);
      $display("test ch1 done");
   endtask

   // channel two across prescale codes 0 to 4; ratio is two to the power code plus one
   task automatic test_ch2();
      int hi, per, code, ratio, n;
      wr(DCPWM_OFF_DUTY2, 8'h80);
      for (code = 0; code < 5; code++) begin
         ratio = 2 << code;
         wr(DCPWM_OFF_ENPS, 8'h00);
         wr(DCPWM_OFF_ENPS, {1'b1, code[2:0], 4'h0});
         check({31'h0, p1_oe_n}, 32'h00000001);
         measure(1'b1, ratio * 512 + 50, 1'b1, hi, per);
         check(per, ratio * 256);
         check(hi, ratio * 128);
      end
      // zero duty from enable: the first period already stays low
      wr(DCPWM_OFF_ENPS, 8'h00);
      wr(DCPWM_OFF_DUTY2, 8'h00);
      wr(DCPWM_OFF_ENPS, 8'h80);
      hi = 0;
      for (n = 0; n < 600; n++) begin
         @(posedge aclk);
         if (lvl2 !== 1'b0) hi++;
      end
      check(hi, 32'd0);
      wr(DCPWM_OFF_ENPS, 8'h00);
      $display("test ch2 done");
   endtask

   // wide mode: channel two's register is the high byte of channel one's duty
   task automatic test_wide();
      int hi, n;
      wr(DCPWM_OFF_DUTY1, 8'h00);
      wr(DCPWM_OFF_DUTY2, 8'h01);
      wr(DCPWM_OFF_RES, 8'h01);
      wr(DCPWM_OFF_ENPS, 8'h08);
      // the first high phase starts after the enable edge, so a window catches it whole
      hi = 0;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (lvl1 === 1'b1) hi++;
      end
      check(hi, 32'd512);
      wr(DCPWM_OFF_ENPS, 8'h00);
      wr(DCPWM_OFF_RES, 8'h00);
      $display("test wide done");
   endtask

   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      mismatches = 0; checks_done = 0;
      aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
      wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      test_regs();
      test_ch1();
      test_ch2();
      test_wide();
      report_and_stop();
   end

   // watchdog: the tests need about 22000 cycles
   initial begin
      #(60000 * 4);
      mismatches++;
      report_and_stop();
   end
endmodule
